/* File: include/gppi_defines.svh */
// Constants for the general-purpose port and pin interrupt block
`ifndef GPPI_DEFINES_SVH
`define GPPI_DEFINES_SVH
`define GPPI_NPORT 2
`define GPPI_PORT_W 32
`define GPPI_NPIN 64
`define GPPI_NCH 8
`define GPPI_SEL_W 6
`define GPPI_SRC_W 3
`define GPPI_RST_OE_N 64'hFFFF_FFFF_FFFF_FFFF
`define GPPI_RST_OUT 64'h0000_0000_0000_0000
`define GPPI_RST_MASK 64'h0000_0000_0000_0000
`define GPPI_RST_RDATA 32'h0000_0000
`endif

/* File: include/gppi_pkg.sv */
// Types shared by the general-purpose port and pin interrupt block
`default_nettype none
package gppi_pkg;
   // Port write operations
   typedef enum logic [2:0] {
      GPPI_OP_DIR = 3'h0,
      GPPI_OP_OUT = 3'h1,
      GPPI_OP_SET = 3'h2,
      GPPI_OP_CLR = 3'h3,
      GPPI_OP_TGL = 3'h4,
      GPPI_OP_MASK = 3'h5,
      GPPI_OP_MPIN = 3'h6,
      GPPI_OP_PIN = 3'h7
   } gppi_op_e;
   // Chip power state seen by the wake logic
   typedef enum logic [1:0] {
      GPPI_PWR_ACTIVE = 2'h0,
      GPPI_PWR_SLEEP = 2'h1,
      GPPI_PWR_DEEP = 2'h2,
      GPPI_PWR_PDOWN = 2'h3
   } gppi_pwr_e;
   // Pattern slice conditions
   typedef enum logic [2:0] {
      GPPI_PM_TRUE = 3'h0,
      GPPI_PM_ST_RISE = 3'h1,
      GPPI_PM_ST_FALL = 3'h2,
      GPPI_PM_ST_EDGE = 3'h3,
      GPPI_PM_HIGH = 3'h4,
      GPPI_PM_LOW = 3'h5,
      GPPI_PM_EV_EDGE = 3'h6,
      GPPI_PM_FALSE = 3'h7
   } gppi_pm_e;
endpackage : gppi_pkg
`default_nettype wire

/* File: logic/gppi_chan.sv */
// One pin interrupt channel: pin select, edge and level detection
`include "gppi_defines.svh"
`default_nettype none
module gppi_chan import gppi_pkg::*; #(
   parameter int NPIN = `GPPI_NPIN,
   parameter int SEL_W = `GPPI_SEL_W
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Synchronised pin levels, now and one cycle ago
   input wire logic [NPIN-1:0] lvl_i,
   input wire logic [NPIN-1:0] prev_i,
   // Channel setup
   input wire logic [SEL_W-1:0] sel_i,
   input wire logic level_mode_i,
   input wire logic rise_en_i,
   input wire logic fall_en_i,
   input wire logic clr_i,
   // Selected pin view and request
   output logic lvl_o,
   output logic rise_o,
   output logic fall_o,
   output logic irq_o
);
   typedef struct packed {
      logic flag;
      logic irq;
   } gppi_chan_s;
   gppi_chan_s q, d;

   // Any pin, whatever function owns it, may be selected
   assign lvl_o = lvl_i[sel_i];
   assign rise_o = lvl_i[sel_i] & ~prev_i[sel_i];
   assign fall_o = ~lvl_i[sel_i] & prev_i[sel_i];

   // Sticky edge flag, a new edge beats a clear in the same cycle
   always_comb begin
      d = q;
      d.flag = (q.flag & ~clr_i) | (rise_en_i & rise_o) | (fall_en_i & fall_o);
      if (level_mode_i) begin
         d.flag = 1'b0;
         d.irq = rise_en_i & (fall_en_i ? ~lvl_o : lvl_o);
      end else begin
         d.irq = d.flag;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign irq_o = q.irq;

   a_edge_fires: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !level_mode_i && rise_en_i && rise_o |=> irq_o)
      else $error("rising edge did not raise the channel request");
   a_level_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      level_mode_i && rise_en_i && !fall_en_i && lvl_o |=> irq_o)
      else $error("high level did not raise the channel request");
endmodule : gppi_chan
`default_nettype wire

/* File: logic/gppi_top.sv */
// General-purpose ports, group interrupts, pin interrupts and pattern match
`include "gppi_defines.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Two ports giving 64 controllable pins
// - Per-bit direction set by software
// - Set and clear writes touch chosen bits
// - Pin read returns real pad level
// - Mask excludes bits from masked access
// - Byte and half-word writes hit only lanes
// - One write loads whole port value
// - Toggle write inverts bits written one
// - All pins are inputs after reset
// - Any pin may raise edge or level request
// - Two group interrupts from pin combinations
// - Group requests wake from sleep, deep, powerdown
// - Eight selectable pins, eight separate requests
// - Edge channels fire rising, falling or both
// - Level channels active high or low
// - Pin requests wake from sleep and deep-sleep
// - Pattern expression over eight selected inputs
// - Each product term raises own request
// - Match may pulse receive event on its own output
// - Pattern wakes only from sleep mode
// - Pin selection ignores current pin function
module gppi_top import gppi_pkg::*; #(
   parameter int NPIN = `GPPI_NPIN,
   parameter int NCH = `GPPI_NCH
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Pads
   input wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0] pin_o,
   output logic [NPIN-1:0] pin_oe_n_o,
   // Port write path
   input wire logic wr_en_i,
   input wire gppi_op_e wr_op_i,
   input wire logic wr_port_i,
   input wire logic [3:0] wr_be_i,
   input wire logic [31:0] wr_data_i,
   // Port read path
   input wire gppi_op_e rd_op_i,
   input wire logic rd_port_i,
   output logic [31:0] rd_data_o,
   // Group interrupts
   input wire logic [2*NPIN-1:0] grp_en_i,
   input wire logic [2*NPIN-1:0] grp_pol_i,
   input wire logic [1:0] grp_and_i,
   input wire logic [1:0] grp_edge_i,
   input wire logic [1:0] grp_clr_i,
   output logic [1:0] grp_irq_o,
   // Pin interrupt channels
   input wire logic [NCH*`GPPI_SEL_W-1:0] pint_sel_i,
   input wire logic [NCH-1:0] pint_level_i,
   input wire logic [NCH-1:0] pint_rise_i,
   input wire logic [NCH-1:0] pint_fall_i,
   input wire logic [NCH-1:0] pint_clr_i,
   output logic [NCH-1:0] pint_irq_o,
   // Pattern match
   input wire logic pm_en_i,
   input wire logic pm_receive_event_pulse_en_i,
   input wire logic [NCH*`GPPI_SRC_W-1:0] pm_src_i,
   input wire logic [NCH*3-1:0] pm_cond_i,
   input wire logic [NCH-1:0] pm_endp_i,
   input wire logic pm_clr_i,
   output logic receive_event_pulse_o,
   // Power state and wake requests
   input wire gppi_pwr_e pwr_state_i,
   output logic grp_wake_o,
   output logic pint_wake_o,
   output logic pm_wake_o
);
   typedef struct packed {
      logic [NPIN-1:0] sync1;
      logic [NPIN-1:0] sync2;
      logic [NPIN-1:0] prev;
      logic [NPIN-1:0] oe_n;
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] mask;
      logic [31:0] rdata;
      logic [1:0] grp_lvl;
      logic [1:0] grp_irq;
      logic [NCH-1:0] st;
      logic [NCH-1:0] term;
      logic [NCH-1:0] irq;
      logic receive_event_pulse;
      logic grp_wake;
      logic pint_wake;
      logic pm_wake;
   } gppi_top_s;
   gppi_top_s q, d;

   logic [NCH-1:0] ch_lvl, ch_rise, ch_fall, ch_irq;
   logic [NCH-1:0] sl_lvl, sl_rise, sl_fall, sl_ok, st_set, acc, term;
   logic [1:0] grp_now;
   logic [31:0] lane, sel, cur_out, cur_oe_n, cur_mask, cur_pin;
   logic [5:0] base;

   ////////////////////////////////////////////////////////////////////////////
   // Pin interrupt channels
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      gppi_chan #(.NPIN(NPIN), .SEL_W(`GPPI_SEL_W)) u_chan (
         .mclk_i(mclk_i),
         .rst_n_i(rst_n_i),
         .lvl_i(q.sync2),
         .prev_i(q.prev),
         .sel_i(pint_sel_i[c*`GPPI_SEL_W +: `GPPI_SEL_W]),
         .level_mode_i(pint_level_i[c]),
         .rise_en_i(pint_rise_i[c]),
         .fall_en_i(pint_fall_i[c]),
         .clr_i(pint_clr_i[c]),
         .lvl_o(ch_lvl[c]),
         .rise_o(ch_rise[c]),
         .fall_o(ch_fall[c]),
         .irq_o(ch_irq[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pattern slices: each reads one channel's pin, AND chains end at endpoints
   for (genvar s = 0; s < NCH; s++) begin : g_slice
      logic [2:0] cnd;
      assign cnd = pm_cond_i[s*3 +: 3];
      assign sl_lvl[s] = ch_lvl[pm_src_i[s*`GPPI_SRC_W +: `GPPI_SRC_W]];
      assign sl_rise[s] = ch_rise[pm_src_i[s*`GPPI_SRC_W +: `GPPI_SRC_W]];
      assign sl_fall[s] = ch_fall[pm_src_i[s*`GPPI_SRC_W +: `GPPI_SRC_W]];
      // Sticky edge memory for the slice
      assign st_set[s] = (cnd == GPPI_PM_ST_RISE && sl_rise[s]) ||
                         (cnd == GPPI_PM_ST_FALL && sl_fall[s]) ||
                         (cnd == GPPI_PM_ST_EDGE && (sl_rise[s] || sl_fall[s]));
      always_comb begin
         case (cnd)
            GPPI_PM_TRUE: sl_ok[s] = 1'b1;
            GPPI_PM_ST_RISE, GPPI_PM_ST_FALL, GPPI_PM_ST_EDGE: sl_ok[s] = q.st[s] | st_set[s];
            GPPI_PM_HIGH: sl_ok[s] = sl_lvl[s];
            GPPI_PM_LOW: sl_ok[s] = ~sl_lvl[s];
            GPPI_PM_EV_EDGE: sl_ok[s] = sl_rise[s] | sl_fall[s];
            default: sl_ok[s] = 1'b0;
         endcase
      end
      // A product term restarts after the previous endpoint
      if (s == 0) begin : g_first
         assign acc[s] = sl_ok[s];
      end else begin : g_next
         assign acc[s] = sl_ok[s] & (pm_endp_i[s-1] | acc[s-1]);
      end
      assign term[s] = acc[s] & pm_endp_i[s];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Group match: enabled pins compared against their polarity, then OR or AND
   for (genvar g = 0; g < 2; g++) begin : g_grp
      logic [NPIN-1:0] en, hit;
      assign en = grp_en_i[g*NPIN +: NPIN];
      assign hit = en & ~(q.sync2 ^ grp_pol_i[g*NPIN +: NPIN]);
      assign grp_now[g] = grp_and_i[g] ? ((&(hit | ~en)) & (|en)) : (|hit);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port slice under access, byte enables widened to a lane mask
   always_comb begin
      base = {wr_port_i, 5'h00};
      lane = {{8{wr_be_i[3]}}, {8{wr_be_i[2]}}, {8{wr_be_i[1]}}, {8{wr_be_i[0]}}};
      cur_out = q.out[base +: 32];
      cur_oe_n = q.oe_n[base +: 32];
      cur_mask = q.mask[base +: 32];
      cur_pin = q.sync2[base +: 32];
      sel = lane & ~cur_mask & wr_data_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;
      // Two flops before any logic sees a pad
      d.sync1 = pin_i;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      // Port writes; only the addressed lanes change
      if (wr_en_i) begin
         case (wr_op_i)
            GPPI_OP_DIR: d.oe_n[base +: 32] = (cur_oe_n & ~lane) | (~wr_data_i & lane);
            GPPI_OP_OUT: d.out[base +: 32] = (cur_out & ~lane) | (wr_data_i & lane);
            GPPI_OP_SET: d.out[base +: 32] = cur_out | (wr_data_i & lane);
            GPPI_OP_CLR: d.out[base +: 32] = cur_out & ~(wr_data_i & lane);
            GPPI_OP_TGL: d.out[base +: 32] = cur_out ^ (wr_data_i & lane);
            GPPI_OP_MASK: d.mask[base +: 32] = (cur_mask & ~lane) | (wr_data_i & lane);
            GPPI_OP_MPIN: begin
               // Masked-out bits keep their value
               d.out[base +: 32] = (cur_out & ~(lane & ~cur_mask)) | sel;
            end
            default: d.out = q.out;
         endcase
      end
      // Read data is registered, one cycle after the request
      case (rd_op_i)
         GPPI_OP_DIR: d.rdata = ~q.oe_n[{rd_port_i, 5'h00} +: 32];
         GPPI_OP_MASK: d.rdata = q.mask[{rd_port_i, 5'h00} +: 32];
         GPPI_OP_PIN: d.rdata = q.sync2[{rd_port_i, 5'h00} +: 32];
         GPPI_OP_MPIN: begin
            d.rdata = q.sync2[{rd_port_i, 5'h00} +: 32] & ~q.mask[{rd_port_i, 5'h00} +: 32];
         end
         default: d.rdata = q.out[{rd_port_i, 5'h00} +: 32];
      endcase
      // Group interrupt: level follows, edge latches until cleared, set wins
      d.grp_lvl = grp_now;
      for (int g = 0; g < 2; g++) begin
         if (grp_edge_i[g]) begin
            d.grp_irq[g] = (q.grp_irq[g] & ~grp_clr_i[g]) | (grp_now[g] & ~q.grp_lvl[g]);
         end else begin
            d.grp_irq[g] = grp_now[g];
         end
      end
      // Pattern sticky slices, set beats clear
      d.st = (q.st & ~{NCH{pm_clr_i}}) | st_set;
      d.term = pm_en_i ? term : '0;
      // Channels carry minterms when pattern mode is on
      d.irq = pm_en_i ? term : ch_irq;
      d.receive_event_pulse = pm_en_i & pm_receive_event_pulse_en_i & (|(term & ~q.term));
      // Wake requests gated by power state
      d.grp_wake = (|q.grp_irq) && pwr_state_i != GPPI_PWR_ACTIVE;
      d.pint_wake = (|q.irq) && !pm_en_i &&
                    (pwr_state_i == GPPI_PWR_SLEEP || pwr_state_i == GPPI_PWR_DEEP);
      d.pm_wake = (|q.irq) && pm_en_i && pwr_state_i == GPPI_PWR_SLEEP;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.oe_n <= `GPPI_RST_OE_N;
         q.out <= `GPPI_RST_OUT;
         q.mask <= `GPPI_RST_MASK;
         q.rdata <= `GPPI_RST_RDATA;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register; 64 pins over two ports
   assign pin_o = q.out;
   assign pin_oe_n_o = q.oe_n;
   assign rd_data_o = q.rdata;
   assign grp_irq_o = q.grp_irq;
   assign pint_irq_o = q.irq;
   assign receive_event_pulse_o = q.receive_event_pulse;
   assign grp_wake_o = q.grp_wake;
   assign pint_wake_o = q.pint_wake;
   assign pm_wake_o = q.pm_wake;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_full_wr0(gppi_op_e op);
      wr_en_i && wr_op_i == op && !wr_port_i && wr_be_i == 4'hF;
   endsequence

   a_pin_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_op_i == GPPI_OP_PIN && !rd_port_i ##1 1'b1 |-> rd_data_o == $past(pin_i[31:0], 3))
      else $error("pin read does not match pad level");
   a_reset_inputs: assert property (@(posedge mclk_i)
      $rose(rst_n_i) |-> &pin_oe_n_o)
      else $error("pin left driving after reset");
   a_set_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_full_wr0(GPPI_OP_SET) |=> (pin_o[31:0] & $past(wr_data_i)) == $past(wr_data_i))
      else $error("set write missed a bit");
   a_clr_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_full_wr0(GPPI_OP_CLR) |=> (pin_o[31:0] & $past(wr_data_i)) == 32'h0000_0000)
      else $error("clear write missed a bit");
   a_toggle_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_full_wr0(GPPI_OP_TGL) |=> pin_o[31:0] == ($past(pin_o[31:0]) ^ $past(wr_data_i)))
      else $error("toggle write wrong");
   a_masked_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wr_en_i && wr_op_i == GPPI_OP_MPIN && !wr_port_i
      |=> ((pin_o[31:0] ^ $past(pin_o[31:0])) & $past(q.mask[31:0])) == 32'h0000_0000)
      else $error("masked write changed a masked bit");
   a_byte_lane: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wr_en_i && wr_op_i == GPPI_OP_OUT && !wr_port_i && wr_be_i == 4'h1
      |=> pin_o[31:8] == $past(pin_o[31:8]))
      else $error("byte write touched other lanes");
   a_full_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_full_wr0(GPPI_OP_OUT) |=> pin_o[31:0] == $past(wr_data_i))
      else $error("whole port write lost");
   a_receive_event_pulse_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      receive_event_pulse_o |=> !receive_event_pulse_o)
      else $error("receive event longer than one cycle");
   a_pm_wake_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      pm_wake_o |-> $past(pwr_state_i) == GPPI_PWR_SLEEP)
      else $error("pattern wake outside sleep");
endmodule : gppi_top
`default_nettype wire

/* File: bench/gppi_pad_model.sv */
// Board-side pad model: pads follow the block where it drives, else the board
`default_nettype none
module gppi_pad_model (
   // Block side
   input wire logic [63:0] pin_o,
   input wire logic [63:0] pin_oe_n_o,
   // Board side
   input wire logic [63:0] ext_i,
   output logic [63:0] pad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Per-bit wire level; the board never leaves a pad floating, so no X reaches pin_i
   always_comb begin
      for (int b = 0; b < 64; b++) begin
         pad_o[b] = pin_oe_n_o[b] ? ext_i[b] : pin_o[b];
      end
   end
endmodule : gppi_pad_model
`default_nettype wire

/* File: bench/gppi_top_bench.sv */
// Self-checking bench for the port, pin interrupt, group and pattern block
`default_nettype none
module gppi_top_bench import gppi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [63:0] ext = 64'h0, pad, pin_o, oe_n;
   logic wr_en = 1'b0, wr_port = 1'b0, rd_port = 1'b0;
   gppi_op_e wr_op = GPPI_OP_PIN, rd_op = GPPI_OP_OUT;
   logic [3:0] wr_be = 4'h0;
   logic [31:0] wr_data = 32'h0, rd_data;
   logic [127:0] grp_en = 128'h0, grp_pol = 128'h0;
   logic [1:0] grp_and = 2'h0, grp_edge = 2'h0, grp_clr = 2'h0, grp_irq;
   logic [47:0] pint_sel = 48'h0;
   logic [7:0] pint_level = 8'h0, pint_rise = 8'h0, pint_fall = 8'h0, pint_clr = 8'h0;
   logic [7:0] pint_irq, pm_endp = 8'h0;
   logic pm_en = 1'b0, pm_receive_event_pulse_en = 1'b0, pm_clr = 1'b0, receive_event_pulse;
   logic [23:0] pm_src = 24'h0, pm_cond = 24'hFFFFFF;
   gppi_pwr_e pwr = GPPI_PWR_ACTIVE;
   logic grp_wake, pint_wake, pm_wake;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   // 25 MHz clock
   always #20 mclk_i = ~mclk_i;
   gppi_pad_model PADS (.pin_o(pin_o), .pin_oe_n_o(oe_n), .ext_i(ext), .pad_o(pad));
   gppi_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pin_i(pad), .pin_o(pin_o),
      .pin_oe_n_o(oe_n), .wr_en_i(wr_en), .wr_op_i(wr_op), .wr_port_i(wr_port),
      .wr_be_i(wr_be), .wr_data_i(wr_data), .rd_op_i(rd_op), .rd_port_i(rd_port),
      .rd_data_o(rd_data), .grp_en_i(grp_en), .grp_pol_i(grp_pol), .grp_and_i(grp_and),
      .grp_edge_i(grp_edge), .grp_clr_i(grp_clr), .grp_irq_o(grp_irq),
      .pint_sel_i(pint_sel), .pint_level_i(pint_level), .pint_rise_i(pint_rise),
      .pint_fall_i(pint_fall), .pint_clr_i(pint_clr), .pint_irq_o(pint_irq),
      .pm_en_i(pm_en), .pm_receive_event_pulse_en_i(pm_receive_event_pulse_en), .pm_src_i(pm_src), .pm_cond_i(pm_cond),
      .pm_endp_i(pm_endp), .pm_clr_i(pm_clr), .receive_event_pulse_o(receive_event_pulse),
      .pwr_state_i(pwr), .grp_wake_o(grp_wake), .pint_wake_o(pint_wake),
      .pm_wake_o(pm_wake));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   // Case-equality compare so an X never counts as a match
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   // One write strobe; pin outputs are settled by the falling edge that ends it
   task automatic wr(input gppi_op_e op, input logic p, input logic [3:0] be,
                     input logic [31:0] d);
      wr_en = 1'b1;
      wr_op = op;
      wr_port = p;
      wr_be = be;
      wr_data = d;
      @(negedge mclk_i);
      wr_en = 1'b0;
      // One idle edge, so a following call never re-raises the strobe in this time step
      @(negedge mclk_i);
   endtask : wr
   // Read select held; registered data checked after the sampling edge
   task automatic rd(input gppi_op_e op, input logic p, input logic [31:0] exp);
      rd_op = op;
      rd_port = p;
      repeat (4) @(negedge mclk_i);
      chk(rd_data, exp, "read data");
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(oe_n, 64'hFFFF_FFFF_FFFF_FFFF, "all inputs after reset");
      chk(pin_o, 64'h0, "output value after reset");
   endtask : t_reset
   // Direction, whole-port, set, clear, toggle, lanes, mask and pad readback
   task automatic t_port();
      wr(GPPI_OP_DIR, 1'b0, 4'hC, 32'hFFFF_FFFF);
      chk(oe_n[31:0], 64'h0000_FFFF, "half-word direction");
      wr(GPPI_OP_DIR, 1'b0, 4'hF, 32'hFFFF_FFFF);
      wr(GPPI_OP_OUT, 1'b0, 4'hF, 32'hA5A5_A5A5);
      wr(GPPI_OP_OUT, 1'b1, 4'hF, 32'h1234_5678);
      chk(pin_o, 64'h1234_5678_A5A5_A5A5, "whole port loads");
      wr(GPPI_OP_SET, 1'b0, 4'h2, 32'h0000_FF0F);
      chk(pin_o[31:0], 64'hA5A5_FFA5, "set one lane");
      wr(GPPI_OP_CLR, 1'b0, 4'hF, 32'h0000_00A0);
      chk(pin_o[31:0], 64'hA5A5_FF05, "clear");
      wr(GPPI_OP_TGL, 1'b0, 4'hF, 32'hFFFF_0000);
      wr(GPPI_OP_PIN, 1'b0, 4'hF, 32'h0);
      chk(pin_o[31:0], 64'h5A5A_FF05, "toggle");
      rd(GPPI_OP_PIN, 1'b0, 32'h5A5A_FF05);
      wr(GPPI_OP_MASK, 1'b0, 4'hF, 32'hFFFF_0000);
      wr(GPPI_OP_MPIN, 1'b0, 4'hF, 32'h0);
      chk(pin_o[31:0], 64'h5A5A_0000, "masked write");
      wr(GPPI_OP_OUT, 1'b0, 4'h1, 32'hFFFF_FF3C);
      chk(pin_o[31:0], 64'h5A5A_003C, "byte write");
      wr(GPPI_OP_SET, 1'b0, 4'hF, 32'h0000_0100);
      chk(pin_o[31:0], 64'h5A5A_013C, "full set");
      wr(GPPI_OP_DIR, 1'b0, 4'hF, 32'h0);
      ext[31:0] = 32'hC3C3_3C3C;
      rd(GPPI_OP_PIN, 1'b0, 32'hC3C3_3C3C);
      chk(oe_n[31:0], 64'hFFFF_FFFF, "back to inputs");
      rd(GPPI_OP_MPIN, 1'b0, 32'h0000_3C3C);
      rd(GPPI_OP_DIR, 1'b0, 32'h0000_0000);
      rd(GPPI_OP_OUT, 1'b1, 32'h1234_5678);
   endtask : t_port
   // Channel 3 on pin 40: rise only, sticky, clear, then level active low
   task automatic t_pint();
      pint_sel[18 +: 6] = 6'h28;
      pint_rise[3] = 1'b1;
      ext[40] = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk(pint_irq[3], 1'b0, "edge not yet through sync");
      repeat (2) @(negedge mclk_i);
      chk(pint_irq[3], 1'b1, "rise request");
      pwr = GPPI_PWR_DEEP;
      repeat (2) @(negedge mclk_i);
      chk(pint_wake, 1'b1, "deep-sleep wake");
      ext[40] = 1'b0;
      repeat (6) @(negedge mclk_i);
      chk(pint_irq[3], 1'b1, "sticky until clear");
      pint_clr[3] = 1'b1;
      @(negedge mclk_i);
      pint_clr[3] = 1'b0;
      repeat (3) @(negedge mclk_i);
      chk(pint_irq[3], 1'b0, "fall ignored");
      pint_level[3] = 1'b1;
      pint_fall[3] = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk(pint_irq[3], 1'b1, "low-active level");
      ext[40] = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk(pint_irq[3], 1'b0, "level follows pin");
      pint_fall[3] = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk(pint_irq[3], 1'b1, "high-active level");
      chk(pint_wake, 1'b1, "deep-sleep level wake");
      pwr = GPPI_PWR_PDOWN;
      repeat (3) @(negedge mclk_i);
      chk(pint_wake, 1'b0, "no power-down wake");
   endtask : t_pint
   // Group 1 is an AND of pins 48 and 49 high; power-down wake
   task automatic t_grp();
      grp_en[112 +: 2] = 2'h3;
      grp_pol[112 +: 2] = 2'h3;
      grp_and = 2'h2;
      ext[48] = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk(grp_irq, 2'h0, "one of two pins");
      ext[49] = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk(grp_irq, 2'h2, "both pins");
      chk(grp_wake, 1'b1, "power-down wake");
      // Edge mode: clear the latch, then a fresh rising match sets it again
      grp_edge = 2'h2;
      grp_clr = 2'h2;
      @(negedge mclk_i);
      grp_clr = 2'h0;
      repeat (2) @(negedge mclk_i);
      chk(grp_irq, 2'h0, "edge mode clear");
      ext[49] = 1'b0;
      repeat (4) @(negedge mclk_i);
      ext[49] = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk(grp_irq, 2'h2, "edge mode latch");
      ext[49] = 1'b0;
      repeat (6) @(negedge mclk_i);
      chk(grp_irq, 2'h2, "latch holds after match ends");
   endtask : t_grp
   // Slice 0 reads channel 3 (pin 40) high and ends the only product term
   task automatic t_pm();
      ext[40] = 1'b0;
      pwr = GPPI_PWR_SLEEP;
      pm_src = 24'h000003;
      pm_cond = 24'hFFFFFC;
      pm_endp = 8'h01;
      pm_en = 1'b1;
      pm_receive_event_pulse_en = 1'b1;
      repeat (6) @(negedge mclk_i);
      ext[40] = 1'b1;
      for (int i = 0; i < 10 && receive_event_pulse !== 1'b1; i++) @(negedge mclk_i);
      chk(receive_event_pulse, 1'b1, "event pulse");
      @(negedge mclk_i);
      chk(receive_event_pulse, 1'b0, "event is one cycle");
      chk(pint_irq[0], 1'b1, "term request");
      chk(pm_wake, 1'b1, "sleep wake");
      pwr = GPPI_PWR_DEEP;
      repeat (3) @(negedge mclk_i);
      chk(pm_wake, 1'b0, "no deep-sleep wake");
      // Two-slice term ending at slice 1: pin 40 low and a rise seen before
      pm_src = 24'h00001B;
      pm_cond = 24'hFFFFCD;
      pm_endp = 8'h02;
      ext[40] = 1'b0;
      repeat (6) @(negedge mclk_i);
      chk(pint_irq[1], 1'b0, "sticky rise not yet seen");
      ext[40] = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk(pint_irq[1], 1'b0, "level slice false");
      ext[40] = 1'b0;
      repeat (6) @(negedge mclk_i);
      chk(pint_irq[1], 1'b1, "rise then low term");
      pm_clr = 1'b1;
      @(negedge mclk_i);
      pm_clr = 1'b0;
      repeat (3) @(negedge mclk_i);
      chk(pint_irq[1], 1'b0, "sticky slice cleared");
   endtask : t_pm
   ////////////////////////////////////////////////////////////////////////////
   // Ceiling well above the fewer than two hundred cycles the scenarios need
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         summarize();
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge mclk_i);
      t_reset();
      rst_n_i = 1'b1;
      @(negedge mclk_i);
      t_reset();
      t_port();
      t_pint();
      t_grp();
      t_pm();
      summarize();
   end
endmodule : gppi_top_bench
`default_nettype wire
